// File: hw/cch_pkg.sv
/*
  Shared constants and carriers for the cyclic command handshake.
  Assumes one bus clock and an APB master; the feed engine sits on the same clock.
*/
package cch_pkg;

  // ----------------------------------------
  // assembly geometry
  // ----------------------------------------
  localparam int        MAX_SLOT = 12;      // command blocks per assembly
  localparam int        ASM_HDR  = 4;       // reserved leading output bytes
  localparam int        BLK_LEN  = 36;      // bytes per slot span

  // ----------------------------------------
  // apb map: slot s at s*0x80, globals above
  // ----------------------------------------
  localparam logic [11:0] A_CTRL  = 12'h700;
  localparam logic [11:0] A_STAT  = 12'h704;
  localparam logic [4:0]  W_ST3   = 5'h05;  // byte 20: status 3, seq, path
  localparam logic [4:0]  W_STS   = 5'h06;  // byte 24: cmd, cstat, xstat, qual
  localparam logic [4:0]  W_DEV   = 5'h07;  // byte 28: deviation
  localparam logic [4:0]  W_RSV   = 5'h08;  // byte 32: reserved
  localparam logic [4:0]  W_CMD   = 5'h10;  // channel, sequence, path
  localparam logic [4:0]  W_ICMD  = 5'h11;  // integer command
  localparam logic [4:0]  W_BCMD  = 5'h12;  // bit command

  // ----------------------------------------
  // field values
  // ----------------------------------------
  localparam logic [7:0]  SEQ_MAX   = 8'h07;
  localparam logic [7:0]  CST_PEND  = 8'h00;  // initial processing running
  localparam logic [7:0]  CST_ILL   = 8'hff;  // illegal command
  localparam logic [7:0]  QUAL_MASK = 8'h07;  // bits 3-7 reserved
  localparam logic        CTRL_RST  = 1'b1;   // commands enabled after reset

  typedef struct packed {
    logic [7:0]  chan;
    logic [7:0]  seq;
    logic [15:0] path;
    logic [7:0]  icmd;
    logic [31:0] bcmd;
  } cch_blk_t;

  typedef struct packed {
    logic [7:0]  chan;
    logic [7:0]  seq;
    logic [15:0] path;
    logic [7:0]  cmd;
  } cch_cmd_t;

  typedef struct packed {
    logic [7:0]  xstat;
    logic [7:0]  qual;
    logic [31:0] dev;
  } cch_feed_t;

  typedef struct packed {
    logic [7:0]  seq;
    logic [15:0] path;
    logic [7:0]  cmd;
    logic [7:0]  cstat;
    logic [7:0]  xstat;
    logic [7:0]  qual;
    logic [31:0] dev;
  } cch_rsp_t;

endpackage

// File: hw/cch_slot.sv
/*
  One channel's trigger detection and response fields.
  Assumes the command block is held stable by the register file between writes.
*/
module cch_slot (
  input  wire logic               pclk,       // bus clock
  input  wire logic               presetn,    // async reset, active low
  input  wire logic               enable,     // global command enable
  input  wire logic               dup,        // channel claimed by a lower slot
  input  wire cch_pkg::cch_blk_t  blk,        // command block from host
  input  wire logic               init_done,  // engine finished initial work
  input  wire logic [7:0]         init_stat,  // resulting command status
  input  wire logic               init_xrej,  // transfer command rejected
  input  wire logic [7:0]         init_xstat, // transfer status on reject
  input  wire logic               feed_done,  // feed completed
  input  wire cch_pkg::cch_feed_t feed_res,   // feed results
  output cch_pkg::cch_cmd_t       cmd_data,   // command to engine
  output logic                    cmd_valid,  // one-cycle command strobe
  output logic                    illegal,    // one-cycle illegal strobe
  output cch_pkg::cch_rsp_t       rsp         // response fields
);
  import cch_pkg::*;

  logic       izero_r;
  logic       bzero_r;
  logic [7:0] bnum;

  // edge detect on both trigger fields
  wire itrig  = izero_r & (blk.icmd != 8'h00);
  wire btrig  = bzero_r & (blk.bcmd != 32'h0);
  wire trig   = enable & (itrig | btrig);
  wire multi  = (blk.bcmd & (blk.bcmd - 32'h1)) != 32'h0;
  wire bad    = dup | (blk.seq > SEQ_MAX) | (!itrig & multi);
  wire [7:0] cnum = itrig ? blk.icmd : bnum;

  // bit position n names command n
  always_comb begin
    bnum = 8'h00;
    for (int i = 0; i < 32; i++) begin
      if (blk.bcmd[i]) begin
        bnum = 8'(i);
      end
    end
  end

  // remember last zero state; a held value never fires again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      izero_r <= 1'b1;
      bzero_r <= 1'b1;
    end else begin
      izero_r <= blk.icmd == 8'h00;
      bzero_r <= blk.bcmd == 32'h0;
    end
  end

  // strobe to engine; illegal commands never reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid <= 1'b0;
      illegal   <= 1'b0;
      cmd_data  <= '0;
    end else begin
      cmd_valid <= trig & !bad;
      illegal   <= trig & bad;
      if (trig) begin
        cmd_data <= '{blk.chan, blk.seq, blk.path, cnum};
      end
    end
  end

  // response fields; later assignments take priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
    end else begin
      if (init_done) begin
        rsp.cstat <= init_stat;
        if (init_xrej) begin
          rsp.xstat <= init_xstat;
        end
      end
      if (trig) begin
        rsp.seq   <= blk.seq;
        rsp.path  <= blk.path;
        rsp.cmd   <= cnum;
        rsp.cstat <= bad ? CST_ILL : CST_PEND;
      end
      if (feed_done) begin
        rsp.xstat <= feed_res.xstat;
        rsp.qual  <= feed_res.qual & QUAL_MASK;
        rsp.dev   <= feed_res.dev;
      end
    end
  end

endmodule

// File: hw/cch_top.sv
/*
  APB register file and slot array for the cyclic command handshake.
  Assumes an APB master on pclk and a feed engine on the same clock.
*/
// Local design decisions: the placing of the registers and the APB slave port.
module cch_top #(
  parameter int NSLOT = 12           // command blocks served
) (
  input  wire logic                          pclk,       // bus clock
  input  wire logic                          presetn,    // async reset, low
  input  wire logic                          psel,       // apb select
  input  wire logic                          penable,    // apb access phase
  input  wire logic                          pwrite,     // apb direction
  input  wire logic [11:0]                   paddr,      // apb byte address
  input  wire logic [31:0]                   pwdata,     // apb write data
  output logic                               pready,     // apb ready
  output logic [31:0]                        prdata,     // apb read data
  output logic                               pslverr,    // apb error
  output logic [NSLOT-1:0]                   cmd_valid,  // command strobes
  output cch_pkg::cch_cmd_t [NSLOT-1:0]      cmd_data,   // commands
  input  wire logic [NSLOT-1:0]              init_done,  // initial work done
  input  wire logic [NSLOT-1:0][7:0]         init_stat,  // command status
  input  wire logic [NSLOT-1:0]              init_xrej,  // transfer rejected
  input  wire logic [NSLOT-1:0][7:0]         init_xstat, // status on reject
  input  wire logic [NSLOT-1:0]              feed_done,  // feed completed
  input  wire cch_pkg::cch_feed_t [NSLOT-1:0] feed_res,  // feed results
  input  wire logic [NSLOT-1:0][2:0]         st3         // fast, drain, jog
);
  import cch_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (NSLOT < 1 || NSLOT > MAX_SLOT) begin : g_bad
    $error("NSLOT must lie in 1..12");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  cch_blk_t          blk_r [NSLOT];
  cch_rsp_t          rsp   [NSLOT];
  logic [NSLOT-1:0]  illegal;
  logic [NSLOT-1:0]  dup;
  logic              ctrl_en_r;
  logic [15:0]       acc_cnt_r;
  logic [15:0]       ill_cnt_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  logic [31:0]       slot_rd [16];
  logic [15:0]       slot_ok;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // slot index from address, word within it
  wire [3:0] slot_idx = paddr[10:7];
  wire [4:0] word     = paddr[6:2];
  wire       in_slot  = !paddr[11] && slot_ok[slot_idx];
  wire       hit_ctrl = paddr == A_CTRL;
  wire       hit_stat = paddr == A_STAT;
  wire       map_ok   = in_slot | hit_ctrl | hit_stat;
  wire       setup    = psel & !penable;
  wire       wr_acc   = psel & penable & pwrite & map_ok;

  // read selection; responses and globals share one mux
  wire [31:0] glob_rd = hit_ctrl ? {31'h0, ctrl_en_r}
                      : {ill_cnt_r, acc_cnt_r};
  wire [31:0] rd_word = in_slot ? slot_rd[slot_idx] : glob_rd;

  // zero wait states, data registered at setup
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // latch read data during setup so it stands from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= (map_ok && !pwrite) ? rd_word : 32'h0;
      pslverr_r <= !map_ok;
    end
  end

  // ----------------------------------------
  // global control and counters
  // ----------------------------------------
  // count accepted and illegal commands across slots
  function automatic logic [15:0] ones(input logic [NSLOT-1:0] v);
    logic [15:0] n;
    n = 16'h0;
    for (int i = 0; i < NSLOT; i++) begin
      n = n + {15'h0, v[i]};
    end
    return n;
  endfunction

  wire clr_cnt = wr_acc & hit_stat;

  // a clear in the same cycle as new events keeps those events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= CTRL_RST;
      acc_cnt_r <= 16'h0;
      ill_cnt_r <= 16'h0;
    end else begin
      if (wr_acc && hit_ctrl) begin
        ctrl_en_r <= pwdata[0];
      end
      acc_cnt_r <= (clr_cnt ? 16'h0 : acc_cnt_r) + ones(cmd_valid);
      ill_cnt_r <= (clr_cnt ? 16'h0 : ill_cnt_r) + ones(illegal);
    end
  end

  // ----------------------------------------
  // duplicate channel detection
  // ----------------------------------------
  // a slot whose channel repeats a lower slot is refused
  always_comb begin
    dup = '0;
    for (int s = 0; s < NSLOT; s++) begin
      for (int j = 0; j < s; j++) begin
        if (blk_r[j].chan == blk_r[s].chan) begin
          dup[s] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // slots
  // ----------------------------------------
  // unused address slots read as unmapped
  for (genvar s = NSLOT; s < 16; s++) begin : g_pad
    assign slot_rd[s] = 32'h0;
    assign slot_ok[s] = 1'b0;
  end

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    // slot s stands for assembly bytes ASM_HDR+s*BLK_LEN onward
    wire sel_s  = wr_acc && in_slot && slot_idx == 4'(s);
    wire rsv_w  = word < W_ST3;

    // words kept per slot; process data below byte 20 reads zero
    assign slot_ok[s] = rsv_w || word == W_ST3 || word == W_STS
                     || word == W_DEV || word == W_RSV
                     || word == W_CMD || word == W_ICMD || word == W_BCMD;

    // response words in input-block byte order
    assign slot_rd[s] =
        word == W_ST3  ? {rsp[s].path, rsp[s].seq, 5'h0, st3[s]}
      : word == W_STS  ? {rsp[s].qual, rsp[s].xstat, rsp[s].cstat, rsp[s].cmd}
      : word == W_DEV  ? rsp[s].dev
      : word == W_CMD  ? {blk_r[s].path, blk_r[s].seq, blk_r[s].chan}
      : word == W_ICMD ? {24'h0, blk_r[s].icmd}
      : word == W_BCMD ? blk_r[s].bcmd
      : 32'h0;

    // command block storage; host writes fields, then the trigger
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        blk_r[s] <= '0;
      end else if (sel_s) begin
        case (word)
          W_CMD: begin
            blk_r[s].chan <= pwdata[7:0];
            blk_r[s].seq  <= pwdata[15:8];
            blk_r[s].path <= pwdata[31:16];
          end
          W_ICMD: begin
            blk_r[s].icmd <= pwdata[7:0];
          end
          W_BCMD: begin
            blk_r[s].bcmd <= pwdata;
          end
          default: begin
          end
        endcase
      end
    end

    cch_slot u_slot (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (ctrl_en_r),
      .dup        (dup[s]),
      .blk        (blk_r[s]),
      .init_done  (init_done[s]),
      .init_stat  (init_stat[s]),
      .init_xrej  (init_xrej[s]),
      .init_xstat (init_xstat[s]),
      .feed_done  (feed_done[s]),
      .feed_res   (feed_res[s]),
      .cmd_data   (cmd_data[s]),
      .cmd_valid  (cmd_valid[s]),
      .illegal    (illegal[s]),
      .rsp        (rsp[s])
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_seq_echo: assert property (
      @(posedge pclk) disable iff (!presetn)
      cmd_valid[s] |-> rsp[s].seq == cmd_data[s].seq && rsp[s].seq <= SEQ_MAX)
      else $error("sequence not echoed");

    chk_path_echo: assert property (
      @(posedge pclk) disable iff (!presetn)
      cmd_valid[s] |-> rsp[s].path == cmd_data[s].path
                    && cmd_data[s].path == blk_r[s].path)
      else $error("path not echoed");

    chk_cmd_echo: assert property (
      @(posedge pclk) disable iff (!presetn)
      cmd_valid[s] |-> rsp[s].cmd == cmd_data[s].cmd && rsp[s].cmd != 8'h00)
      else $error("command not echoed");

    chk_init_status: assert property (
      @(posedge pclk) disable iff (!presetn)
      init_done[s] && $stable(blk_r[s].icmd) && $stable(blk_r[s].bcmd)
      |=> rsp[s].cstat == $past(init_stat[s]))
      else $error("command status not stored");

    chk_feed_result: assert property (
      @(posedge pclk) disable iff (!presetn)
      feed_done[s] |=> rsp[s].dev == $past(feed_res[s].dev)
                    && rsp[s].xstat == $past(feed_res[s].xstat)
                    && rsp[s].qual[7:3] == 5'h00)
      else $error("feed result not stored");

    chk_no_retrig: assert property (
      @(posedge pclk) disable iff (!presetn)
      $stable(blk_r[s].icmd) && $stable(blk_r[s].bcmd)
      |=> !cmd_valid[s] && !illegal[s])
      else $error("held command fired again");

    chk_int_trigger: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(blk_r[s].icmd) == 8'h00 && blk_r[s].icmd != 8'h00 && ctrl_en_r
      |=> (cmd_valid[s] ^ illegal[s]) && rsp[s].cmd == $past(blk_r[s].icmd))
      else $error("integer trigger missed");

    chk_multi_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(blk_r[s].bcmd) == 32'h0 && $past(blk_r[s].icmd) == 8'h00
      && blk_r[s].icmd == 8'h00 && $countones(blk_r[s].bcmd) > 1 && ctrl_en_r
      |=> illegal[s] && !cmd_valid[s] && rsp[s].cstat == CST_ILL)
      else $error("multi-bit command not refused");

    // a single bit n must strobe the engine and echo command n in the response
    chk_bit_trigger: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(blk_r[s].bcmd) == 32'h0 && $past(blk_r[s].icmd) == 8'h00
      && blk_r[s].icmd == 8'h00 && $countones(blk_r[s].bcmd) == 1 && ctrl_en_r
      && !dup[s] && blk_r[s].seq <= SEQ_MAX
      |=> cmd_valid[s] && (32'h1 << rsp[s].cmd) == $past(blk_r[s].bcmd))
      else $error("bit trigger missed");

    // a channel already served by a lower slot never reaches the engine
    chk_dup_refused: assert property (
      @(posedge pclk) disable iff (!presetn)
      dup[s] && $past(blk_r[s].icmd) == 8'h00 && blk_r[s].icmd != 8'h00
      |=> !cmd_valid[s])
      else $error("duplicate channel accepted");
  end

  chk_rsv_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && !paddr[11] && paddr[6:2] == W_RSV
    |=> prdata == 32'h0 && pready)
    else $error("reserved word not zero");

  // with commands disabled no slot may strobe or flag anything
  chk_cmd_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_en_r |=> cmd_valid == '0 && illegal == '0)
    else $error("command fired while disabled");

endmodule

// File: testbench/cch_engine.sv
/*
  Feed engine stand-in that answers the command strobes of each slot.
  Assumes the slots share its clock; slow stretches every answer.
*/
module cch_engine #(
  parameter int NSLOT = 2                   // slots served
) (
  input  wire logic                          pclk,       // bus clock
  input  wire logic                          presetn,    // async reset, low
  input  wire logic                          slow,       // long answer delay
  input  wire logic [NSLOT-1:0]              cmd_valid,  // command strobes
  input  wire cch_pkg::cch_cmd_t [NSLOT-1:0] cmd_data,   // commands
  output logic [NSLOT-1:0]                   init_done,  // initial work done
  output logic [NSLOT-1:0][7:0]              init_stat,  // command status
  output logic [NSLOT-1:0]                   init_xrej,  // transfer rejected
  output logic [NSLOT-1:0][7:0]              init_xstat, // status on reject
  output logic [NSLOT-1:0]                   feed_done,  // feed completed
  output cch_pkg::cch_feed_t [NSLOT-1:0]     feed_res    // feed results
);
  timeunit 1ns;
  timeprecision 1ps;
  import cch_pkg::*;

  // ----
  // per-slot answer timing
  // ----
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    logic [4:0] cnt_r;
    logic [7:0] cmd_r;
    logic [4:0] dly;
    // status echoes the command so each answer is traceable
    assign dly           = slow ? 5'h0c : 5'h02;
    assign init_done[s]  = (cnt_r == dly);
    assign feed_done[s]  = (cnt_r == 2 * dly) && (cmd_r == 8'h01);
    assign init_stat[s]  = cmd_r;
    assign init_xrej[s]  = (cmd_r == 8'h02);
    assign init_xstat[s] = 8'h22;
    // qualifier carries reserved bits on purpose: the slot must drop them
    assign feed_res[s]   = {8'h10, 8'hff, 32'h3f80_0000};
    // a new strobe restarts the count, so stale answers never leak
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= 5'h00;
        cmd_r <= 8'h00;
      end else if (cmd_valid[s]) begin
        cnt_r <= 5'h01;
        cmd_r <= cmd_data[s].cmd;
      end else if (cnt_r == 2 * dly) begin
        cnt_r <= 5'h00;
      end else if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end
endmodule

// File: testbench/tb.sv
/*
  Self-checking bench: APB host sequences against two command slots.
  Assumes the engine stand-in answers strobes on the same clock.
*/
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cch_pkg::*;

  localparam int NS = 2;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel, penable, pwrite, pready, pslverr, slow, rerr;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rdat;
  logic [NS-1:0]         cmd_valid, init_done, init_xrej, feed_done;
  cch_cmd_t [NS-1:0]     cmd_data;
  cch_feed_t [NS-1:0]    feed_res;
  logic [NS-1:0][7:0]    init_stat, init_xstat;
  logic [NS-1:0][2:0]    st3;
  int                    n_mismatch, n_compared, nv[NS];

  always #5 pclk = ~pclk;

  cch_top #(.NSLOT(NS)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .cmd_valid, .cmd_data, .init_done, .init_stat,
    .init_xrej, .init_xstat, .feed_done, .feed_res, .st3);
  cch_engine #(.NSLOT(NS)) eng (.pclk, .presetn, .slow, .cmd_valid, .cmd_data, .init_done,
    .init_stat, .init_xrej, .init_xstat, .feed_done, .feed_res);

  // count strobes per slot; a retrigger shows up as an extra count
  always @(posedge pclk) begin
    for (int s = 0; s < NS; s++) if (cmd_valid[s] === 1'b1) nv[s]++;
  end

  // ----
  // bus tasks
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_mismatch++;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK($sformatf("rd %h", a), e, rdat)
    `CHK($sformatf("err %h", a), ee, rerr)
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch; the sequence needs well under 10 us
  initial begin
    #50us;
    n_mismatch++;
    wrap_up();
  end

  // ----
  // sequences
  // ----
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    st3     = 6'b010_101;
    slow    = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(12'h018, 32'h0, 1'b0);
    // integer trigger with a slow engine: pending status is visible
    apb(1'b1, 12'h040, 32'h0123_0305);
    apb(1'b1, 12'h044, 32'h1);
    rc(12'h014, 32'h0123_0305, 1'b0);
    rc(12'h018, 32'h0000_0001, 1'b0);
    `CHK("strobe0", 1, nv[0])
    wt(30);
    rc(12'h018, 32'h0710_0101, 1'b0);
    rc(12'h01c, 32'h3f80_0000, 1'b0);
    rc(12'h020, 32'h0, 1'b0);
    // rewriting the same nonzero value must not fire again
    apb(1'b1, 12'h044, 32'h1);
    wt(3);
    `CHK("held", 1, nv[0])
    // next sequence, transfer command that the engine rejects
    slow <= 1'b0;
    apb(1'b1, 12'h044, 32'h0);
    apb(1'b1, 12'h040, 32'h0123_0405);
    apb(1'b1, 12'h044, 32'h2);
    wt(10);
    rc(12'h018, 32'h0722_0202, 1'b0);
    rc(12'h014, 32'h0123_0405, 1'b0);
    // bit field: bit 13 means command 13
    apb(1'b1, 12'h044, 32'h0);
    apb(1'b1, 12'h040, 32'h0123_0505);
    apb(1'b1, 12'h048, 32'h0000_2000);
    wt(10);
    rc(12'h018, 32'h0722_0d0d, 1'b0);
    // two bits set is refused with the highest bit echoed
    apb(1'b1, 12'h048, 32'h0);
    apb(1'b1, 12'h040, 32'h0123_0605);
    apb(1'b1, 12'h048, 32'h0000_0006);
    wt(10);
    rc(12'h018, 32'h0722_ff02, 1'b0);
    `CHK("strobe1", 3, nv[0])
    rc(12'h704, 32'h0001_0003, 1'b0);
    // sequence number above 7
    apb(1'b1, 12'h048, 32'h0);
    apb(1'b1, 12'h040, 32'h0123_0805);
    apb(1'b1, 12'h044, 32'h1);
    wt(3);
    rc(12'h018, 32'h0722_ff01, 1'b0);
    // slot 1 reusing slot 0's channel is refused, its own is taken
    apb(1'b1, 12'h0c0, 32'h0001_0105);
    apb(1'b1, 12'h0c4, 32'h3);
    wt(3);
    rc(12'h098, 32'h0000_ff03, 1'b0);
    apb(1'b1, 12'h0c4, 32'h0);
    apb(1'b1, 12'h0c0, 32'h0001_0206);
    apb(1'b1, 12'h0c4, 32'h3);
    wt(10);
    rc(12'h098, 32'h0000_0303, 1'b0);
    `CHK("strobe2", 1, nv[1])
    rc(12'h094, 32'h0001_0202, 1'b0);
    `CHK("cmd1", {8'h06, 8'h02, 16'h0001, 8'h03}, cmd_data[1])
    // counters: three refused, four accepted; any write clears them
    rc(12'h704, 32'h0003_0004, 1'b0);
    apb(1'b1, 12'h704, 32'h0);
    rc(12'h704, 32'h0, 1'b0);
    // disabled: a fresh trigger gives no strobe and is not counted
    apb(1'b1, 12'h700, 32'h0);
    rc(12'h700, 32'h0, 1'b0);
    apb(1'b1, 12'h0c4, 32'h0);
    apb(1'b1, 12'h0c4, 32'h5);
    wt(3);
    `CHK("disabled", 1, nv[1])
    rc(12'h704, 32'h0, 1'b0);
    // reset in mid-run restores the enable and clears the responses
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    rc(12'h700, 32'h1, 1'b0);
    rc(12'h098, 32'h0, 1'b0);
    // only NSLOT blocks exist, and the word right after a block's reserved word is unmapped
    rc(12'h100, 32'h0, 1'b1);
    rc(12'h024, 32'h0, 1'b1);
    wrap_up();
  end
endmodule
